/* rtl/srcc_map.vh */
`ifndef SRCC_MAP_VH
`define SRCC_MAP_VH

// Register offsets
`define SRCC_ADDR_DUTY_ONE    16'h011C
`define SRCC_ADDR_DUTY_TWO    16'h011E
`define SRCC_ADDR_CFG         16'h0120
`define SRCC_ADDR_IGN         16'h0121

// Reset values
`define SRCC_RST_DUTY         8'h03
`define SRCC_RST_CFG          8'h00
`define SRCC_RST_IGN          8'h00

// Duty stabilizer control fields
`define SRCC_DUTY_ENABLE_BIT  1
`define SRCC_DUTY_PWRUP_BIT   0

// Capture config fields
`define SRCC_CFG_FLAGRST_BIT  6
`define SRCC_CFG_POL_BIT      4
`define SRCC_CFG_EDGE_BIT     3
`define SRCC_CFG_MODE_HI      2
`define SRCC_CFG_MODE_LO      1
`define SRCC_CFG_RW_MASK      8'h5E

// Ignore count field
`define SRCC_IGN_HI           3
`define SRCC_IGN_LO           0
`define SRCC_IGN_RW_MASK      8'h0F

// Capture mode encodings
`define SRCC_MODE_OFF         2'h0
`define SRCC_MODE_CONT        2'h1
`define SRCC_MODE_NSHOT       2'h2

`endif

/* rtl/srcc_edge_sampler.v */
`timescale 1ns/1ps
`include "srcc_map.vh"

module srcc_edge_sampler (
  input  wire sys_clk,
  input  wire rst,
  input  wire sysrefIn,
  input  wire fallEdgeSel,
  input  wire highToLow,
  output reg  transPulse_r
);

  reg posSample_r;
  reg negSample_r;
  reg prevSample_r;
  wire selSample;
  wire transNxt;

  ////////////////////////////////////////////////////////////////////////////
  // Sampling on both clock edges
  always @(posedge sys_clk) begin
    if (rst) begin
      posSample_r <= 1'b0;
    end else begin
      posSample_r <= sysrefIn;
    end
  end

  always @(negedge sys_clk) begin
    if (rst) begin
      negSample_r <= 1'b0;
    end else begin
      negSample_r <= sysrefIn;
    end
  end

  assign selSample = fallEdgeSel ? negSample_r : posSample_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transition detection; both paths compare against the same history so
  // a polarity change while capture is idle cannot fake a transition
  assign transNxt = highToLow ? (prevSample_r & ~selSample)
                              : (~prevSample_r & selSample);

  always @(posedge sys_clk) begin
    if (rst) begin
      prevSample_r <= 1'b0;
      transPulse_r <= 1'b0;
    end else begin
      prevSample_r <= selSample;
      transPulse_r <= transNxt;
    end
  end

endmodule

/* rtl/srcc_capture_ctrl.v */
`timescale 1ns/1ps
`include "srcc_map.vh"

// Functional notes
// - Flag-reset bit set holds setup and hold error flags cleared.
// - Polarity 0 accepts rising SYSREF transitions; 1 accepts falling ones.
// - Edge bit 0 samples on rising clock edge; 1 on falling edge.
// - Mode field: 0 disabled, 1 continuous, 2 N-shot capture.
// - Ignore count skips that many initial transitions before an N-shot capture acts; continuous mode ignores it.
module srcc_capture_ctrl (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [15:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWrEn,
  input  wire       regRdEn,
  output reg  [7:0] regRdData_r,
  output reg        regRdValid_r,
  input  wire       sysrefIn,
  input  wire       setupErrIn,
  input  wire       holdErrIn,
  output reg        setupErrFlag_r,
  output reg        holdErrFlag_r,
  output reg        sysrefSync_r,
  output wire       nShotDone,
  output wire       firstDutyStabilizerEn,
  output wire       firstDutyStabilizerPwrUp,
  output wire       secondDutyStabilizerEn,
  output wire       secondDutyStabilizerPwrUp
);

  localparam [1:0] ST_OFF   = 2'd0;
  localparam [1:0] ST_CONT  = 2'd1;
  localparam [1:0] ST_ARMED = 2'd2;
  localparam [1:0] ST_DONE  = 2'd3;

  reg  [7:0] dutyOne_r;
  reg  [7:0] dutyTwo_r;
  reg  [7:0] capCfg_r;
  reg  [7:0] ignCnt_r;
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [3:0] skipCnt_r;
  reg  [3:0] skipCnt_nxt;
  reg        sync_nxt;
  wire       transPulse;
  wire       cfgWrite;
  wire [1:0] modeSel;
  wire [1:0] newMode;
  wire [3:0] ignSel;
  wire [3:0] wrSel;
  wire [3:0] rdSel;

  function [1:0] mode_state;
    input [1:0] mode;
    begin
      case (mode)
        `SRCC_MODE_CONT:  mode_state = ST_CONT;
        `SRCC_MODE_NSHOT: mode_state = ST_ARMED;
        default:          mode_state = ST_OFF;
      endcase
    end
  endfunction

  // One-hot register select, shared by the write and read paths
  function [3:0] reg_sel;
    input [15:0] addr;
    begin
      case (addr)
        `SRCC_ADDR_DUTY_ONE: reg_sel = 4'h1;
        `SRCC_ADDR_DUTY_TWO: reg_sel = 4'h2;
        `SRCC_ADDR_CFG:      reg_sel = 4'h4;
        `SRCC_ADDR_IGN:      reg_sel = 4'h8;
        default:             reg_sel = 4'h0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  assign wrSel    = regWrEn ? reg_sel(regAddr) : 4'h0;
  assign rdSel    = regRdEn ? reg_sel(regAddr) : 4'h0;
  assign cfgWrite = wrSel[2];
  assign modeSel  = capCfg_r[`SRCC_CFG_MODE_HI:`SRCC_CFG_MODE_LO];
  assign newMode  = regWrData[`SRCC_CFG_MODE_HI:`SRCC_CFG_MODE_LO];
  assign ignSel   = ignCnt_r[`SRCC_IGN_HI:`SRCC_IGN_LO];

  always @(posedge sys_clk) begin
    if (rst) begin
      dutyOne_r <= `SRCC_RST_DUTY;
      dutyTwo_r <= `SRCC_RST_DUTY;
      capCfg_r  <= `SRCC_RST_CFG;
      ignCnt_r  <= `SRCC_RST_IGN;
    end else begin
      if (wrSel[0]) begin
        dutyOne_r <= regWrData;
      end
      if (wrSel[1]) begin
        dutyTwo_r <= regWrData;
      end
      // Reserved read-only bits stay zero
      if (wrSel[2]) begin
        capCfg_r <= regWrData & `SRCC_CFG_RW_MASK;
      end
      if (wrSel[3]) begin
        ignCnt_r <= regWrData & `SRCC_IGN_RW_MASK;
      end
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      regRdData_r  <= 8'h00;
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRdEn;
      if (regRdEn) begin
        // Unmapped addresses read as zero
        case (rdSel)
          4'h1:    regRdData_r <= dutyOne_r;
          4'h2:    regRdData_r <= dutyTwo_r;
          4'h4:    regRdData_r <= capCfg_r;
          4'h8:    regRdData_r <= ignCnt_r;
          default: regRdData_r <= 8'h00;
        endcase
      end
    end
  end

  // Stabilizer controls feed the clock path directly, with no shadowing
  assign firstDutyStabilizerEn     = dutyOne_r[`SRCC_DUTY_ENABLE_BIT];
  assign firstDutyStabilizerPwrUp  = dutyOne_r[`SRCC_DUTY_PWRUP_BIT];
  assign secondDutyStabilizerEn    = dutyTwo_r[`SRCC_DUTY_ENABLE_BIT];
  assign secondDutyStabilizerPwrUp = dutyTwo_r[`SRCC_DUTY_PWRUP_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Error flags: sticky until the hold-in-reset bit or rst. The hold bit
  // beats a same-cycle error event, since the flags must read cleared
  // for as long as the bit is set
  always @(posedge sys_clk) begin
    if (rst || capCfg_r[`SRCC_CFG_FLAGRST_BIT]) begin
      setupErrFlag_r <= 1'b0;
      holdErrFlag_r  <= 1'b0;
    end else begin
      if (setupErrIn) begin
        setupErrFlag_r <= 1'b1;
      end
      if (holdErrIn) begin
        holdErrFlag_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sampler; polarity is assumed steady whenever capture is enabled
  srcc_edge_sampler uSampler (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .sysrefIn     (sysrefIn),
    .fallEdgeSel  (capCfg_r[`SRCC_CFG_EDGE_BIT]),
    .highToLow    (capCfg_r[`SRCC_CFG_POL_BIT]),
    .transPulse_r (transPulse)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Capture mode machine. Any write to the config register re-derives the
  // state from the written mode, so rewriting N-shot rearms it.
  always @* begin
    state_nxt   = state_r;
    skipCnt_nxt = skipCnt_r;
    sync_nxt    = 1'b0;
    // The ignore count is latched only when the mode is written, so
    // software loads it first; a strobe in the write cycle is dropped
    if (cfgWrite) begin
      state_nxt   = mode_state(newMode);
      skipCnt_nxt = ignSel;
    end else begin
      case (state_r)
        ST_CONT: begin
          sync_nxt = transPulse;
        end
        ST_ARMED: begin
          if (transPulse) begin
            if (skipCnt_r == 4'h0) begin
              sync_nxt  = 1'b1;
              state_nxt = ST_DONE;
            end else begin
              skipCnt_nxt = skipCnt_r - 4'h1;
            end
          end
        end
        ST_OFF: begin
        end
        ST_DONE: begin
        end
        default: begin
          state_nxt = ST_OFF;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_r      <= ST_OFF;
      skipCnt_r    <= 4'h0;
      sysrefSync_r <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      skipCnt_r    <= skipCnt_nxt;
      sysrefSync_r <= sync_nxt;
    end
  end

  assign nShotDone = (state_r == ST_DONE);

endmodule

/* dv/srcc_sysref_src.sv */
`timescale 1ns/1ps
module srcc_sysref_src (
  input  wire       sys_clk,
  input  wire       fire,
  input  wire       idleHi,
  input  wire [3:0] width,
  output reg        sysrefOut
);
  reg [3:0] cnt_r;
  initial begin
    cnt_r = 4'h0;
    sysrefOut = 1'b0;
  end
  // A pulse lasts width clocks, so at least two when width is 2 or more, so both levels are seen
  always @(posedge sys_clk) begin
    cnt_r <= fire ? width : (cnt_r != 4'h0 ? cnt_r - 4'h1 : cnt_r);
    sysrefOut <= #1 idleHi ^ (fire || cnt_r > 4'h1);
  end
endmodule

/* dv/srcc_capture_ctrl_sva.sv */
`timescale 1ns/1ps
module srcc_capture_ctrl_sva (
  input wire        sys_clk,
  input wire        rst,
  input wire [15:0] regAddr,
  input wire [7:0]  regWrData,
  input wire        regWrEn,
  input wire        regRdEn,
  input wire [7:0]  regRdData_r,
  input wire        regRdValid_r,
  input wire        setupErrIn,
  input wire        holdErrIn,
  input wire        setupErrFlag_r,
  input wire        holdErrFlag_r,
  input wire        sysrefSync_r,
  input wire        nShotDone,
  input wire        firstDutyStabilizerEn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  reg  frz_r;
  wire cfgWr = regWrEn && regAddr == 16'h0120;
  always @(posedge sys_clk) frz_r <= rst ? 1'b0 : cfgWr ? regWrData[6] : frz_r;
  reg  offMode_r;
  // Mode codes 0 and 3 both leave capture disabled
  always @(posedge sys_clk)
    offMode_r <= rst ? 1'b1
               : cfgWr ? (regWrData[2] == regWrData[1]) : offMode_r;
  sequence s_badRd; regRdEn && regAddr == 16'h0122; endsequence
  property p_rdAns; regRdEn |=> regRdValid_r; endproperty
  a_rdAns: assert property (p_rdAns) else $error("read not answered");
  property p_rdOne; !regRdEn |=> !regRdValid_r; endproperty
  a_rdOne: assert property (p_rdOne) else $error("stray read valid");
  property p_badRd; s_badRd |=> regRdData_r == 8'h00; endproperty
  a_badRd: assert property (p_badRd) else $error("unmapped read not zero");
  property p_dcs; regWrEn && regAddr == 16'h011C
    |=> firstDutyStabilizerEn == $past(regWrData[1]); endproperty
  a_dcs: assert property (p_dcs) else $error("stabilizer enable wrong");
  property p_frz; frz_r |=> !setupErrFlag_r && !holdErrFlag_r; endproperty
  a_frz: assert property (p_frz) else $error("flag not held");
  property p_set; !frz_r && !cfgWr && setupErrIn |=> setupErrFlag_r;
  endproperty
  a_set: assert property (p_set) else $error("flag not set");
  property p_sync; sysrefSync_r |=> !sysrefSync_r; endproperty
  a_sync: assert property (p_sync) else $error("sync too long");
  property p_once; nShotDone && !cfgWr |=> !sysrefSync_r; endproperty
  a_once: assert property (p_once) else $error("second shot");
  property p_hold; !frz_r && holdErrIn |=> holdErrFlag_r; endproperty
  a_hold: assert property (p_hold) else $error("hold flag not set");
  property p_off; offMode_r |=> !sysrefSync_r; endproperty
  a_off: assert property (p_off) else $error("sync while disabled");
  sequence s_fire; $rose(nShotDone); endsequence
  property p_shot; s_fire |-> sysrefSync_r; endproperty
  a_shot: assert property (p_shot) else $error("shot without sync");
endmodule
bind srcc_capture_ctrl srcc_capture_ctrl_sva chk_u (.sys_clk, .rst, .regAddr,
  .regWrData, .regWrEn, .regRdEn, .regRdData_r, .regRdValid_r, .setupErrIn,
  .holdErrIn, .setupErrFlag_r, .holdErrFlag_r, .sysrefSync_r, .nShotDone,
  .firstDutyStabilizerEn);

/* dv/srcc_capture_ctrl_bench.sv */
`timescale 1ns/1ps
module srcc_capture_ctrl_bench;
  reg         sys_clk, rst, regWrEn, regRdEn, setupErrIn, holdErrIn;
  reg         fire, idleHi;
  reg  [15:0] regAddr;
  reg  [7:0]  regWrData;
  reg  [3:0]  width;
  reg  [31:0] seed;
  wire [7:0]  regRdData_r;
  wire        regRdValid_r, setupErrFlag_r, holdErrFlag_r;
  wire        sysrefSync_r, nShotDone, sysrefIn;
  wire        firstDutyStabilizerEn, firstDutyStabilizerPwrUp;
  wire        secondDutyStabilizerEn, secondDutyStabilizerPwrUp;
  wire [3:0]  dutyOut = {firstDutyStabilizerEn, firstDutyStabilizerPwrUp,
                         secondDutyStabilizerEn, secondDutyStabilizerPwrUp};
  reg  [3:0]  dutyExp;
  reg         syncExp;
  integer     err_count, checks, i;
  reg  [7:0]  rdQ[$];
  reg         syncQ[$];
  always #12.5 sys_clk = ~sys_clk;
  srcc_capture_ctrl dut_u (.sys_clk, .rst, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData_r, .regRdValid_r, .sysrefIn, .setupErrIn,
    .holdErrIn, .setupErrFlag_r, .holdErrFlag_r, .sysrefSync_r, .nShotDone,
    .firstDutyStabilizerEn, .firstDutyStabilizerPwrUp,
    .secondDutyStabilizerEn, .secondDutyStabilizerPwrUp);
  srcc_sysref_src src_u (.sys_clk, .fire, .idleHi, .width,
    .sysrefOut(sysrefIn));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task cmp(input string nm, input [7:0] e, input [7:0] g);
    checks = checks + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task step(input integer n);
    repeat (n) begin @(posedge sys_clk); #1; end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    regAddr = a; regWrData = d; regWrEn = 1; step(1); regWrEn = 0; step(1);
  endtask
  task rd(input [15:0] a, input [7:0] e);
    regAddr = a; rdQ.push_back(e); regRdEn = 1; step(1); regRdEn = 0; step(1);
  endtask
  task srf(input integer n, input integer ex);
    repeat (ex) syncQ.push_back(1'b1);
    repeat (n) begin
      width = seed[2:0] + 4'h2; seed = lfsr(seed);
      fire = 1; step(1); fire = 0; step(12);
    end
    cmp("pending", 8'h00, syncQ.size());
  endtask
  task results;
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge sys_clk) begin
    if (regRdValid_r) cmp("regRdData_r", rdQ.pop_front(), regRdData_r);
    if (sysrefSync_r) begin
      syncExp = (syncQ.size() > 0) ? syncQ.pop_front() : 1'b0;
      cmp("sysrefSync_r", {7'h0, syncExp}, {7'h0, sysrefSync_r});
    end
  end
  initial begin
    #(25 * 5000); err_count = err_count + 1; results;
  end
  initial begin
    sys_clk = 0; rst = 1; regWrEn = 0; regRdEn = 0; setupErrIn = 0;
    holdErrIn = 0; fire = 0; idleHi = 0; regAddr = 16'h0000;
    regWrData = 8'h00; width = 4'h2; seed = 32'h84fe_f532;
    err_count = 0; checks = 0;
    step(12); rst = 0;
    dutyExp = 4'hF;
    cmp("dutyOut", {4'h0, dutyExp}, {4'h0, dutyOut});
    rd(16'h011C, 8'h03); rd(16'h011E, 8'h03); rd(16'h0120, 8'h00);
    rd(16'h0121, 8'h00); rd(16'h0122, 8'h00);
    wr(16'h0120, 8'hFF); rd(16'h0120, 8'h5E);
    wr(16'h0121, 8'hFF); rd(16'h0121, 8'h0F);
    for (i = 0; i < 2; i++) begin
      wr(i ? 16'h011E : 16'h011C, seed[7:0]);
      rd(i ? 16'h011E : 16'h011C, seed[7:0]);
      dutyExp = i ? {dutyExp[3:2], seed[1:0]} : {seed[1:0], dutyExp[1:0]};
      cmp("dutyOut", {4'h0, dutyExp}, {4'h0, dutyOut});
      seed = lfsr(seed);
    end
    wr(16'h0120, 8'h00); setupErrIn = 1; holdErrIn = 1; step(1);
    setupErrIn = 0; holdErrIn = 0; step(1);
    cmp("flags", 8'h03, {6'h0, setupErrFlag_r, holdErrFlag_r});
    wr(16'h0120, 8'h40); setupErrIn = 1; holdErrIn = 1; step(2);
    cmp("flags", 8'h00, {6'h0, setupErrFlag_r, holdErrFlag_r});
    setupErrIn = 0; holdErrIn = 0;
    // Both polarities and clock edges, boundary ignore counts, N-shot
    for (i = 0; i < 4; i++) begin
      wr(16'h0120, {3'b000, idleHi, 4'h0});
      idleHi = i[1]; wr(16'h0120, {3'b000, idleHi, 4'h0}); step(4);
      wr(16'h0121, {4'h0, i[0] ? 4'hF : 4'h0});
      wr(16'h0120, {3'b000, idleHi, i[0], 3'b100});
      cmp("nShotDone", 8'h00, {7'h0, nShotDone});
      srf(i[0] ? 17 : 2, 1);
      cmp("nShotDone", 8'h01, {7'h0, nShotDone});
    end
    wr(16'h0120, 8'h12); srf(3, 3);
    cmp("nShotDone", 8'h00, {7'h0, nShotDone});
    wr(16'h0120, 8'h10); srf(2, 0);
    wr(16'h0120, 8'h16); srf(2, 0);
    step(5); cmp("pending", 8'h00, syncQ.size());
    results;
  end
endmodule
